//--- pim_pkg.sv
// constants for the peripheral interrupt and clock map block
`default_nettype none
package pim_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          NSRC            = 32;
    localparam int          NLEVEL          = 8;
    // register offsets (byte addresses)
    localparam logic [11:0] OFF_MODE_BASE   = 12'h000;
    localparam logic [11:0] OFF_VEC_BASE    = 12'h080;
    localparam logic [11:0] OFF_CUR_VEC     = 12'h100;
    localparam logic [11:0] OFF_FAST_VEC    = 12'h104;
    localparam logic [11:0] OFF_CUR_SRC     = 12'h108;
    localparam logic [11:0] OFF_PENDING     = 12'h10c;
    localparam logic [11:0] OFF_MASK        = 12'h110;
    localparam logic [11:0] OFF_CORE_STAT   = 12'h114;
    localparam logic [11:0] OFF_EN_SET      = 12'h120;
    localparam logic [11:0] OFF_EN_CLR      = 12'h124;
    localparam logic [11:0] OFF_PEND_CLR    = 12'h128;
    localparam logic [11:0] OFF_PEND_SET    = 12'h12c;
    localparam logic [11:0] OFF_END_SVC     = 12'h130;
    localparam logic [11:0] OFF_SPUR_VEC    = 12'h134;
    localparam logic [11:0] OFF_DEBUG       = 12'h138;
    localparam logic [11:0] OFF_FF_SET      = 12'h140;
    localparam logic [11:0] OFF_FF_CLR      = 12'h144;
    localparam logic [11:0] OFF_FF_STAT     = 12'h148;
    localparam logic [11:0] OFF_CLK_SET     = 12'h150;
    localparam logic [11:0] OFF_CLK_CLR     = 12'h154;
    localparam logic [11:0] OFF_CLK_STAT    = 12'h158;
    localparam logic [11:0] OFF_EVT_STAT    = 12'h160;
    localparam logic [11:0] OFF_EVT_MASK    = 12'h164;
    // source mode fields and the debug protect bit
    localparam int          MODE_W          = 7;
    localparam int          MODE_EDGE_BIT   = 5;
    localparam int          MODE_POS_BIT    = 6;
    localparam int          DEBUG_PROT_BIT  = 0;
    // identifiers
    localparam logic [4:0]  ID_FAST         = 5'h00;
    localparam logic [4:0]  ID_SYSTEM       = 5'h01;
    localparam logic [4:0]  ID_ADC          = 5'h05;
    localparam logic [4:0]  ID_EXT0         = 5'h1d;
    localparam int          N_SYS_SRC       = 7;
    localparam int          N_EXT           = 3;
    // sources that exist (15 and 16 reserved)
    localparam logic [31:0] SRC_VALID       = 32'hfffe7fff;
    // identifiers with a software clock gate
    localparam logic [31:0] CLK_CTRL_MASK   = 32'h1fee7fdc;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    // event status bits
    localparam int          EVT_NORM        = 0;
    localparam int          EVT_FAST        = 1;
    localparam int          EVT_SPUR        = 2;
    localparam int          N_EVT           = 3;
endpackage : pim_pkg
`default_nettype wire

//--- pim_irq_clock_map.sv
// peripheral identifier to interrupt source and clock gate map with vectored controller
//
// What this block does
// RULE1 - one identifier indexes both the interrupt source and the clock gate bit
// RULE2 - identifiers: 0 fast, 1 system, 2..28 peripherals, 29..31 external lines
// RULE3 - source 1 is the OR of the seven system peripheral interrupts
// RULE4 - system peripheral clocks never gate off; identifier 1 only for interrupts
// RULE5 - clock set/clear of 0,1,5,20,29..31 changes no clock gate
// RULE6 - ADC clock starts on first conversion, stops after each one in sleep
// RULE7 - fast and external lines have identifiers without any clock control
// RULE8 - each source selects edge or level, positive/high or negative/low
// RULE9 - eight-level priority on sources 1..31, higher preempts lower service
// RULE10 - source 0 drives the fast line; source 1 is the system source
// RULE11 - fast forcing sends any normal source to the fast output
// RULE12 - one vector per source; current vector read returns served vector
// RULE13 - protect mode stops reads from causing side effects
// RULE14 - identifiers 15 and 16 have no input, no gate, read zero
//
// The placing of the registers and the address-and-strobe port were decided locally.
`default_nettype none
module pim_irq_clock_map (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic [11:0]              addr,
    input  wire logic [31:0]              wr_data,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    output logic      [31:0]              rd_data,
    input  wire logic [31:0]              periph_irq,
    input  wire logic [6:0]               system_interrupt_source,
    input  wire logic                     fast_interrupt,
    input  wire logic [2:0]               external_irq_line,
    input  wire logic                     adc_conv_start,
    input  wire logic                     adc_conv_done,
    input  wire logic                     sleep_mode,
    output logic                          normal_irq_output_n,
    output logic                          fast_irq_output_n,
    output logic      [31:0]              periph_clk_en,
    output logic                          adc_clk_en,
    output logic                          sys_clk_en,
    output logic                          irq_out
);
    // ************************************************************
    // pin synchronisers and source assembly
    // ************************************************************
    logic [3:0]  pin_meta_reg;
    logic [3:0]  pin_sync_reg;
    logic [31:0] src_raw;
    logic [31:0] src_prev_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {external_irq_line, fast_interrupt};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_comb begin
        src_raw     = periph_irq & pim_pkg::SRC_VALID;                   // [RULE2] [RULE14]
        src_raw[0]  = pin_sync_reg[0];                                   // [RULE10]
        src_raw[1]  = |system_interrupt_source;                          // [RULE3]
        src_raw[31:29] = pin_sync_reg[3:1];                              // [RULE7]
    end

    // ************************************************************
    // register bus decode
    // ************************************************************
    logic [pim_pkg::MODE_W-1:0] mode_reg [pim_pkg::NSRC];
    logic [31:0] vec_reg [pim_pkg::NSRC];
    logic [31:0] mask_reg;
    logic [31:0] ff_reg;
    logic [31:0] gate_reg;
    logic [31:0] spur_reg;
    logic        prot_reg;
    logic [pim_pkg::N_EVT-1:0] evt_reg;
    logic [pim_pkg::N_EVT-1:0] evt_mask_reg;
    logic        is_mode;
    logic        is_vec;
    logic        ack;
    logic [4:0]  wr_idx;

    assign is_mode = (addr & 12'hf80) == pim_pkg::OFF_MODE_BASE;
    assign is_vec  = (addr & 12'hf80) == pim_pkg::OFF_VEC_BASE;
    assign wr_idx  = addr[6:2];
    // protect mode moves the acknowledge from the read to a write of the same register
    assign ack = prot_reg ? (wr_en && addr == pim_pkg::OFF_CUR_VEC)
                          : (rd_en && addr == pim_pkg::OFF_CUR_VEC);     // [RULE13]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < pim_pkg::NSRC; i++) begin
                mode_reg[i] <= '0;
                vec_reg[i]  <= pim_pkg::RST_ZERO;
            end
        end else if (wr_en && pim_pkg::SRC_VALID[wr_idx]) begin
            if (is_mode)
                mode_reg[wr_idx] <= wr_data[pim_pkg::MODE_W-1:0];         // [RULE8]
            if (is_vec)
                vec_reg[wr_idx] <= wr_data;                              // [RULE12]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg     <= pim_pkg::RST_ZERO;
            ff_reg       <= pim_pkg::RST_ZERO;
            spur_reg     <= pim_pkg::RST_ZERO;
            prot_reg     <= 1'b0;
            evt_mask_reg <= '0;
        end else if (wr_en) begin
            case (addr)
                pim_pkg::OFF_EN_SET:   mask_reg <= mask_reg | (wr_data & pim_pkg::SRC_VALID);
                pim_pkg::OFF_EN_CLR:   mask_reg <= mask_reg & ~wr_data;
                pim_pkg::OFF_FF_SET:   ff_reg   <= ff_reg | (wr_data & pim_pkg::SRC_VALID & 32'hffff_fffe); // [RULE11]
                pim_pkg::OFF_FF_CLR:   ff_reg   <= ff_reg & ~wr_data;
                pim_pkg::OFF_SPUR_VEC: spur_reg <= wr_data;
                pim_pkg::OFF_DEBUG:    prot_reg <= wr_data[pim_pkg::DEBUG_PROT_BIT];
                pim_pkg::OFF_EVT_MASK: evt_mask_reg <= wr_data[pim_pkg::N_EVT-1:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // pending logic
    // ************************************************************
    logic [31:0] pend_reg;
    logic [31:0] hit;
    logic [31:0] lvl;
    logic [31:0] edge_sel;
    logic [31:0] pend_clr;
    logic [31:0] pend_set;

    always_comb begin
        for (int i = 0; i < pim_pkg::NSRC; i++) begin
            edge_sel[i] = mode_reg[i][pim_pkg::MODE_EDGE_BIT];
            lvl[i] = mode_reg[i][pim_pkg::MODE_POS_BIT] ? src_raw[i] : ~src_raw[i];      // [RULE8]
            hit[i] = mode_reg[i][pim_pkg::MODE_POS_BIT] ? (src_raw[i] & ~src_prev_reg[i])
                                                         : (~src_raw[i] & src_prev_reg[i]); // [RULE8]
        end
    end

    logic [4:0]  best_src;
    logic [2:0]  best_pri;
    logic        best_any;
    logic        irq_cond;
    logic [31:0] fast_cand;
    logic [31:0] norm_cand;

    always_comb begin
        pend_clr = '0;
        pend_set = '0;
        if (wr_en && addr == pim_pkg::OFF_PEND_CLR)
            pend_clr = wr_data;
        if (wr_en && addr == pim_pkg::OFF_PEND_SET)
            pend_set = wr_data;
        if (ack && irq_cond)
            pend_clr[best_src] = 1'b1;
        if (rd_en && !prot_reg && addr == pim_pkg::OFF_FAST_VEC)
            pend_clr[0] = 1'b1;                                          // [RULE13]
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_prev_reg <= pim_pkg::RST_ZERO;
            pend_reg     <= pim_pkg::RST_ZERO;
        end else begin
            src_prev_reg <= src_raw;
            // a new edge in the clearing cycle is kept
            pend_reg <= ((edge_sel & (((pend_reg & ~pend_clr) | hit | pend_set)))
                       | (~edge_sel & lvl)) & pim_pkg::SRC_VALID;         // [RULE8] [RULE14]
        end
    end

    // ************************************************************
    // priority resolver and nesting stack
    // ************************************************************
    logic [2:0]  stk_pri [pim_pkg::NLEVEL];
    logic [4:0]  stk_src [pim_pkg::NLEVEL];
    logic [3:0]  depth_reg;
    logic [2:0]  top;
    logic [2:0]  cur_pri;

    assign fast_cand = pend_reg & mask_reg & (ff_reg | 32'h0000_0001);  // [RULE10] [RULE11]
    assign norm_cand = pend_reg & mask_reg & ~ff_reg & 32'hffff_fffe;
    assign top       = 3'(depth_reg - 4'h1);
    assign cur_pri   = stk_pri[top];

    always_comb begin
        best_any = 1'b0;
        best_pri = 3'h0;
        best_src = 5'h00;
        // downward scan with >= lets the lowest identifier win a tie
        for (int i = pim_pkg::NSRC - 1; i >= 1; i--) begin
            if (norm_cand[i] && (!best_any || mode_reg[i][2:0] >= best_pri)) begin
                best_any = 1'b1;
                best_pri = mode_reg[i][2:0];
                best_src = 5'(i);
            end
        end
    end

    // a deeper interrupt must beat the level in service
    assign irq_cond = best_any && (depth_reg == 4'h0 || best_pri > cur_pri); // [RULE9]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            depth_reg <= 4'h0;
            for (int i = 0; i < pim_pkg::NLEVEL; i++) begin
                stk_pri[i] <= 3'h0;
                stk_src[i] <= 5'h00;
            end
        end else if (ack && irq_cond && depth_reg < 4'(pim_pkg::NLEVEL)) begin
            stk_pri[depth_reg[2:0]] <= best_pri;                         // [RULE9]
            stk_src[depth_reg[2:0]] <= best_src;
            depth_reg <= depth_reg + 4'h1;
        end else if (wr_en && addr == pim_pkg::OFF_END_SVC && depth_reg != 4'h0) begin
            depth_reg <= depth_reg - 4'h1;                               // [RULE9]
        end
    end

    // ************************************************************
    // core outputs and clock gates
    // ************************************************************
    logic adc_clk_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            normal_irq_output_n <= 1'b1;
            fast_irq_output_n   <= 1'b1;
        end else begin
            normal_irq_output_n <= ~irq_cond;                            // [RULE9]
            fast_irq_output_n   <= ~(|fast_cand);                        // [RULE10] [RULE11]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate_reg <= pim_pkg::RST_ZERO;
        end else if (wr_en && addr == pim_pkg::OFF_CLK_SET) begin
            gate_reg <= gate_reg | (wr_data & pim_pkg::CLK_CTRL_MASK);   // [RULE1] [RULE5] [RULE7]
        end else if (wr_en && addr == pim_pkg::OFF_CLK_CLR) begin
            gate_reg <= gate_reg & ~(wr_data & pim_pkg::CLK_CTRL_MASK);  // [RULE5]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            adc_clk_reg <= 1'b0;
        end else if (adc_conv_start) begin
            adc_clk_reg <= 1'b1;                                         // [RULE6]
        end else if (adc_conv_done && sleep_mode) begin
            adc_clk_reg <= 1'b0;                                         // [RULE6]
        end
    end

    assign periph_clk_en = gate_reg;
    assign adc_clk_en    = adc_clk_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            sys_clk_en <= 1'b1;
        else
            sys_clk_en <= 1'b1;                                          // [RULE4]
    end

    // ************************************************************
    // event status, interrupt out and read data
    // ************************************************************
    logic [pim_pkg::N_EVT-1:0] evt_hit;
    logic                      evt_rd;
    logic                      irq_prev_reg;
    logic                      fast_prev_reg;

    assign evt_hit[pim_pkg::EVT_NORM] = irq_cond & ~irq_prev_reg;
    assign evt_hit[pim_pkg::EVT_FAST] = (|fast_cand) & ~fast_prev_reg;
    assign evt_hit[pim_pkg::EVT_SPUR] = ack & ~irq_cond;
    assign evt_rd = rd_en && !prot_reg && addr == pim_pkg::OFF_EVT_STAT;  // [RULE13]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            evt_reg       <= '0;
            irq_prev_reg  <= 1'b0;
            fast_prev_reg <= 1'b0;
            irq_out       <= 1'b0;
        end else begin
            irq_prev_reg  <= irq_cond;
            fast_prev_reg <= |fast_cand;
            // set beats the read-clear
            evt_reg <= (evt_rd ? '0 : evt_reg) | evt_hit;
            irq_out <= |(((evt_rd ? '0 : evt_reg) | evt_hit) & evt_mask_reg);
        end
    end

    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_mode)
            rd_val = {25'h0, mode_reg[wr_idx]};
        else if (is_vec)
            rd_val = vec_reg[wr_idx];
        else begin
            case (addr)
                pim_pkg::OFF_CUR_VEC:   rd_val = irq_cond ? vec_reg[best_src] : spur_reg; // [RULE12]
                pim_pkg::OFF_FAST_VEC:  rd_val = vec_reg[0];
                pim_pkg::OFF_CUR_SRC:   rd_val = {27'h0, (depth_reg == 4'h0) ? 5'h00 : stk_src[top]};
                pim_pkg::OFF_PENDING:   rd_val = pend_reg;
                pim_pkg::OFF_MASK:      rd_val = mask_reg;
                pim_pkg::OFF_CORE_STAT: rd_val = {30'h0, ~fast_irq_output_n, ~normal_irq_output_n};
                pim_pkg::OFF_SPUR_VEC:  rd_val = spur_reg;
                pim_pkg::OFF_DEBUG:     rd_val = {31'h0, prot_reg};
                pim_pkg::OFF_FF_STAT:   rd_val = ff_reg;
                pim_pkg::OFF_CLK_STAT:  rd_val = gate_reg | (32'(adc_clk_reg) << pim_pkg::ID_ADC); // [RULE1]
                pim_pkg::OFF_EVT_STAT:  rd_val = {29'h0, evt_reg};
                pim_pkg::OFF_EVT_MASK:  rd_val = {29'h0, evt_mask_reg};
                default:                rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rd_data <= 32'h0000_0000;
        else
            rd_data <= rd_en ? rd_val : 32'h0000_0000;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    logic [31:0] best_vec;
    assign best_vec = vec_reg[best_src];

    property p_sys_or;
        @(posedge clk) disable iff (!nrst) (|system_interrupt_source) |-> src_raw[1];
    endproperty
    a_sys_or: assert property (p_sys_or) else $error("system source not merged"); // [RULE3]

    property p_resv_zero;
        @(posedge clk) disable iff (!nrst) pend_reg[16:15] == 2'b00 && mask_reg[16:15] == 2'b00;
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved source active"); // [RULE14]

    property p_no_gate;
        @(posedge clk) disable iff (!nrst) (periph_clk_en & ~pim_pkg::CLK_CTRL_MASK) == 32'h0;
    endproperty
    a_no_gate: assert property (p_no_gate) else $error("gate on uncontrolled id"); // [RULE5]

    property p_sys_clk;
        @(posedge clk) disable iff (!nrst) sys_clk_en;
    endproperty
    a_sys_clk: assert property (p_sys_clk) else $error("system clock gated"); // [RULE4]

    property p_adc_start;
        @(posedge clk) disable iff (!nrst) adc_conv_start |=> adc_clk_en;
    endproperty
    a_adc_start: assert property (p_adc_start) else $error("adc clock not started"); // [RULE6]

    property p_adc_stop;
        @(posedge clk) disable iff (!nrst) sleep_mode && adc_conv_done && !adc_conv_start |=> !adc_clk_en;
    endproperty
    a_adc_stop: assert property (p_adc_stop) else $error("adc clock not stopped"); // [RULE6]

    property p_protect;
        @(posedge clk) disable iff (!nrst) prot_reg && rd_en && !wr_en |=> $stable(depth_reg);
    endproperty
    a_protect: assert property (p_protect) else $error("read changed state in protect"); // [RULE13]

    property p_pop;
        @(posedge clk) disable iff (!nrst)
            wr_en && addr == pim_pkg::OFF_END_SVC && depth_reg != 4'h0 |=> depth_reg == $past(depth_reg) - 4'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("end of service did not pop"); // [RULE9]

    property p_fast;
        @(posedge clk) disable iff (!nrst) (|(pend_reg & mask_reg & ff_reg)) || (pend_reg[0] && mask_reg[0])
            |=> !fast_irq_output_n;
    endproperty
    a_fast: assert property (p_fast) else $error("fast output missing"); // [RULE11]

    property p_vector;
        @(posedge clk) disable iff (!nrst) ack && rd_en && irq_cond |=> rd_data == $past(best_vec);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong current vector"); // [RULE12]

    c_nest:  cover property (@(posedge clk) disable iff (!nrst) depth_reg == 4'h2);
    c_spur:  cover property (@(posedge clk) disable iff (!nrst) evt_hit[pim_pkg::EVT_SPUR]);
    c_force: cover property (@(posedge clk) disable iff (!nrst) |(pend_reg & mask_reg & ff_reg));
endmodule // pim_irq_clock_map
`default_nettype wire

//--- pim_periph_model.sv
// far-side model: peripherals and pins that raise interrupt lines
`default_nettype none
module pim_periph_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [31:0] req_irq,
    input  wire logic [6:0]  req_sys,
    input  wire logic        req_fast,
    input  wire logic [2:0]  req_ext,
    output logic      [31:0] periph_irq,
    output logic      [6:0]  system_interrupt_source,
    output logic             fast_interrupt,
    output logic      [2:0]  external_irq_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // lines change only on the clock
    // ****************************************
    // reserved ids never carry a line, so they are held low here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            periph_irq              <= 32'h0;
            system_interrupt_source <= 7'h0;
            fast_interrupt          <= 1'b0;
            external_irq_line       <= 3'h0;
        end else begin
            periph_irq              <= req_irq & pim_pkg::SRC_VALID;
            system_interrupt_source <= req_sys;
            fast_interrupt          <= req_fast;
            external_irq_line       <= req_ext;
        end
    end
endmodule // pim_periph_model
`default_nettype wire

//--- tb_pim_irq_clock_map.sv
// self-checking testbench for the peripheral interrupt and clock map block
`default_nettype none
module tb_pim_irq_clock_map;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, nrst = 0, wr_en = 0, rd_en = 0, req_fast = 0;
    logic        adc_conv_start = 0, adc_conv_done = 0, sleep_mode = 0;
    logic [11:0] addr = 0;
    logic [31:0] wr_data = 0, req_irq = 0, rd_data, periph_irq, periph_clk_en, d, gate_m, spur_m;
    logic [6:0]  req_sys = 0, system_interrupt_source;
    logic [2:0]  req_ext = 0, external_irq_line;
    logic        fast_interrupt, normal_irq_output_n, fast_irq_output_n, adc_clk_en, sys_clk_en, irq_out;
    int          bad_count = 0, cmp_count = 0, seed = 60, r, i;
    logic [31:0] vec_m [32];
    int          stk_m [$];
    pim_periph_model pim_periph_model_inst (.clk(clk), .nrst(nrst), .req_irq(req_irq), .req_sys(req_sys),
        .req_fast(req_fast), .req_ext(req_ext), .periph_irq(periph_irq),
        .system_interrupt_source(system_interrupt_source),
        .fast_interrupt(fast_interrupt), .external_irq_line(external_irq_line));
    pim_irq_clock_map pim_irq_clock_map_inst (.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .periph_irq(periph_irq),
        .system_interrupt_source(system_interrupt_source), .fast_interrupt(fast_interrupt),
        .external_irq_line(external_irq_line), .adc_conv_start(adc_conv_start), .adc_conv_done(adc_conv_done),
        .sleep_mode(sleep_mode), .normal_irq_output_n(normal_irq_output_n), .fast_irq_output_n(fast_irq_output_n),
        .periph_clk_en(periph_clk_en), .adc_clk_en(adc_clk_en), .sys_clk_en(sys_clk_en), .irq_out(irq_out));
    // ****************************************
    // bus cycles and comparisons
    // ****************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ack(input int n);
        rd(pim_pkg::OFF_CUR_VEC);
        chk(d, vec_m[n]);
        stk_m.push_back(n);
    endtask
    task automatic eoi;
        wr(pim_pkg::OFF_END_SVC, 32'h0);
        void'(stk_m.pop_back());
    endtask
    task automatic cur;
        rd(pim_pkg::OFF_CUR_SRC);
        chk(d, (stk_m.size() > 0) ? stk_m[$] : 0);
    endtask
    // bounded wait for an interrupt line to reach a level
    task automatic wt(input bit f, input logic w);
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            #1;
            if ((f ? fast_irq_output_n : normal_irq_output_n) === w) break;
        end
        chk({31'h0, f ? fast_irq_output_n : normal_irq_output_n}, {31'h0, w});
    endtask
    task automatic setq(input int b, input logic v);
        @(posedge clk);
        req_irq[b] <= v;
    endtask
    task automatic final_report;
        if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 6000);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(periph_clk_en, 32'h0);
        chk({30'h0, sys_clk_en, adc_clk_en}, 32'h2);
        wr(pim_pkg::OFF_CLK_SET, 32'hffffffff);
        gate_m = pim_pkg::CLK_CTRL_MASK;
        #1;
        chk(periph_clk_en, gate_m);
        r = $random(seed);
        wr(pim_pkg::OFF_CLK_CLR, r);
        gate_m = gate_m & ~r;
        rd(pim_pkg::OFF_CLK_STAT);
        chk(d, gate_m);
        chk({31'h0, sys_clk_en}, 32'h1);
        @(posedge clk);
        adc_conv_start <= 1'b1;
        @(posedge clk);
        adc_conv_start <= 1'b0;
        adc_conv_done <= 1'b1;
        #1;
        chk({31'h0, adc_clk_en}, 32'h1);
        @(posedge clk);
        sleep_mode <= 1'b1;
        #1;
        chk({31'h0, adc_clk_en}, 32'h1);
        @(posedge clk);
        adc_conv_done <= 1'b0;
        #1;
        chk({31'h0, adc_clk_en}, 32'h0);
        chk(periph_clk_en, gate_m);
        for (i = 0; i < 32; i++) begin
            vec_m[i] = $random(seed);
            wr(pim_pkg::OFF_VEC_BASE + 12'(4 * i), vec_m[i]);
            if (!pim_pkg::SRC_VALID[i]) vec_m[i] = 32'h0;
        end
        spur_m = $random(seed);
        wr(pim_pkg::OFF_SPUR_VEC, spur_m);
        wr(pim_pkg::OFF_MODE_BASE + 12'h03c, 32'h7f);
        rd(pim_pkg::OFF_MODE_BASE + 12'h03c);
        chk(d, 32'h0);
        rd(pim_pkg::OFF_VEC_BASE + 12'h040);
        chk(d, 32'h0);
        rd(12'h1f0);
        chk(d, 32'h0);
        wr(pim_pkg::OFF_MODE_BASE + 12'h000, 32'h40);
        wr(pim_pkg::OFF_MODE_BASE + 12'h004, 32'h43);
        wr(pim_pkg::OFF_MODE_BASE + 12'h008, 32'h42);
        wr(pim_pkg::OFF_MODE_BASE + 12'h00c, 32'h45);
        wr(pim_pkg::OFF_MODE_BASE + 12'h010, 32'h61);
        wr(pim_pkg::OFF_EVT_MASK, 32'h3);
        // source 4 kept the pending bit of its level-low reset mode
        wr(pim_pkg::OFF_PEND_CLR, 32'h10);
        @(posedge clk);
        req_sys <= 7'h1 << ($unsigned($random(seed)) % 7);
        wr(pim_pkg::OFF_EN_SET, 32'h1e);
        wt(0, 1'b0);
        ack(1);
        cur();
        req_sys <= 7'h0;
        eoi();
        setq(2, 1'b1);
        wt(0, 1'b0);
        ack(2);
        setq(3, 1'b1);
        wt(0, 1'b0);
        ack(3);
        cur();
        setq(3, 1'b0);
        eoi();
        cur();
        wr(pim_pkg::OFF_DEBUG, 32'h1);
        rd(pim_pkg::OFF_CUR_VEC);
        chk(d, spur_m);
        cur();
        setq(2, 1'b0);
        eoi();
        setq(4, 1'b1);
        wt(0, 1'b0);
        rd(pim_pkg::OFF_CUR_VEC);
        chk(d, vec_m[4]);
        cur();
        wr(pim_pkg::OFF_CUR_VEC, 32'h0);
        stk_m.push_back(4);
        cur();
        eoi();
        wr(pim_pkg::OFF_DEBUG, 32'h0);
        wt(0, 1'b1);
        setq(4, 1'b0);
        rd(pim_pkg::OFF_EVT_STAT);
        req_fast <= 1'b1;
        wr(pim_pkg::OFF_EN_SET, 32'h1);
        wt(1, 1'b0);
        chk({31'h0, irq_out}, 32'h1);
        rd(pim_pkg::OFF_EVT_STAT);
        chk(d & 32'h2, 32'h2);
        chk({31'h0, irq_out}, 32'h0);
        req_fast <= 1'b0;
        wt(1, 1'b1);
        wr(pim_pkg::OFF_FF_SET, 32'h4);
        setq(2, 1'b1);
        wt(1, 1'b0);
        chk({31'h0, normal_irq_output_n}, 32'h1);
        setq(2, 1'b0);
        wr(pim_pkg::OFF_FF_CLR, 32'h4);
        wr(pim_pkg::OFF_EN_SET, 32'h40);
        wt(0, 1'b0);
        setq(6, 1'b1);
        wt(0, 1'b1);
        wr(pim_pkg::OFF_MODE_BASE + 12'h074, 32'h47);
        wr(pim_pkg::OFF_EN_SET, 32'h2000_0000);
        req_ext <= 3'h1;
        wt(0, 1'b0);
        ack(29);
        final_report();
    end
endmodule // tb_pim_irq_clock_map
`default_nettype wire
